//--- include/rpm_pkg.sv
// Shared constants, types and the tolerance check of the reference period monitor.
package rpm_pkg;

  // Sizes of the monitor array and its profile fields.
  localparam int NREF   = 8;
  localparam int NPROF  = 8;
  localparam int REF_W  = 3;
  localparam int PROF_W = 3;
  localparam int PER_W  = 50;
  localparam int TOL_W  = 20;
  localparam int VAL_W  = 16;
  localparam int PRIO_W = 3;
  localparam int CFG_W  = 4;
  localparam int CNT_W  = 26;
  localparam int SPER_W = 25;
  localparam int MS_W   = 16;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Register offsets; the update register always reads back zero.
  localparam logic [ADDR_W-1:0] ADDR_UPDATE = 16'h0005;
  localparam logic [ADDR_W-1:0] ADDR_DETECT = 16'h0a0d;
  localparam logic [ADDR_W-1:0] ADDR_FAULT  = 16'h0d00;
  localparam logic [ADDR_W-1:0] ADDR_VALID  = 16'h0d01;

  // Field positions.
  localparam int UPDATE_BIT = 0;
  localparam int CFG_MANUAL = 3;

  // Validation timer unit and the system clock period, both in ns.
  localparam int UNIT_NS   = 1000000;
  localparam int CLK_NS    = 20;
  localparam int MS_CYCLES = UNIT_NS / CLK_NS;

  // Period counter saturates here, which marks a dead reference.
  localparam logic [CNT_W-1:0] CNT_MAX = '1;

  // Per-reference profile assignment states.
  typedef enum logic [2:0] {
    ASG_IDLE = 3'h1,
    ASG_RUN  = 3'h2,
    ASG_DONE = 3'h4
  } rpm_asg_e;

  // True when |meas-nom| * tol <= nom, i.e. deviation within 1/tol.
  function automatic logic rpm_within(input logic [PER_W-1:0] meas,
                                      input logic [PER_W-1:0] nom,
                                      input logic [TOL_W-1:0] tol);
    logic [PER_W-1:0]       dev;
    logic [PER_W+TOL_W-1:0] prod;
    dev  = (meas > nom) ? meas - nom : nom - meas;
    prod = dev * tol;
    return prod <= {{TOL_W{1'b0}}, nom};
  endfunction : rpm_within

endpackage : rpm_pkg

//--- core/rpm_ref_mon.sv
// One reference period monitor with its fault hysteresis and valid latch.
`timescale 1ns/100ps
module rpm_ref_mon (
  // Clock, reset and freeze.
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire logic                       ce,
  // Reference pin, asynchronous to clk.
  input  wire logic                       ref_in,
  // Committed settings for this reference.
  input  wire logic [rpm_pkg::SPER_W-1:0] sysclk_period,
  input  wire logic [rpm_pkg::PER_W-1:0]  nom,
  input  wire logic [rpm_pkg::TOL_W-1:0]  tol_inner,
  input  wire logic [rpm_pkg::TOL_W-1:0]  tol_outer,
  input  wire logic [rpm_pkg::VAL_W-1:0]  val_ms,
  // Enable, millisecond tick and manual validation.
  input  wire logic                       mon_en,
  input  wire logic                       ms_tick,
  input  wire logic                       force_val,
  // Results.
  output logic [rpm_pkg::PER_W-1:0]       meas,
  output logic                            meas_done,
  output logic                            faulted,
  output logic                            valid
);
  import rpm_pkg::*;

  logic             ref_s1, ref_s2, ref_s3, armed;
  logic [CNT_W-1:0] cnt;
  logic [VAL_W-1:0] vcnt;
  logic             next_faulted, next_valid;

  // Edge detect sits on the second stage so the first stage only feeds a flop.
  wire                     edge_ev   = ref_s2 & ~ref_s3;
  wire                     stale     = (cnt == CNT_MAX);
  wire [CNT_W-1:0]         cnt_inc   = cnt + 1'b1;
  // R17: cycles times period
  wire [CNT_W+SPER_W-1:0]  prod      = cnt_inc * sysclk_period;
  wire [PER_W-1:0]         next_meas = prod[PER_W-1:0];
  wire                     in_inner  = rpm_within(next_meas, nom, tol_inner);
  wire                     in_outer  = rpm_within(next_meas, nom, tol_outer);
  wire                     timer_hit = (val_ms != '0) && (vcnt >= val_ms);

  // Fault decision, evaluated on every measured period.
  always_comb begin
    next_faulted = faulted;
    // R1: fault until stable
    if (!mon_en || stale) begin
      next_faulted = 1'b1;
    // R3: every measurement used
    end else if (edge_ev && armed) begin
      // R7: inner tolerance clears; R8: outer tolerance sets
      next_faulted = faulted ? !in_inner : !in_outer;
    end
  end

  // Valid latch: a fault wins over the timer and the manual force.
  always_comb begin
    // R15: fault forces invalid
    if (next_faulted) begin
      next_valid = 1'b0;
    // R16: zero disables timer
    end else if (force_val || timer_hit) begin
      next_valid = 1'b1;
    end else begin
      next_valid = valid;
    end
  end

  // Synchroniser and period counter; the first edge only arms the count.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ref_s1    <= 1'b0;
      ref_s2    <= 1'b0;
      ref_s3    <= 1'b0;
      armed     <= 1'b0;
      cnt       <= '0;
      meas      <= '0;
      meas_done <= 1'b0;
    end else if (ce) begin
      ref_s1    <= ref_in;
      ref_s2    <= ref_s1;
      ref_s3    <= ref_s2;
      meas_done <= edge_ev && armed;
      if (edge_ev) begin
        armed <= 1'b1;
        cnt   <= '0;
        meas  <= next_meas;
      end else if (!stale) begin
        cnt <= cnt_inc;
      end
    end
  end

  // Fault, valid and validation timer; the timer restarts on every fault.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      faulted <= 1'b1;
      valid   <= 1'b0;
      vcnt    <= '0;
    end else if (ce) begin
      faulted <= next_faulted;
      valid   <= next_valid;
      if (faulted) begin
        vcnt <= '0;
      end else if (ms_tick && !timer_hit) begin
        vcnt <= vcnt + 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_unstable_fault;
    ce && !mon_en |=> faulted;
  endproperty
  a_unstable_fault: assert property (p_unstable_fault) else $error("not faulted while disabled"); // R1

  property p_inner_clear;
    ce && mon_en && !stale && edge_ev && armed && faulted && in_inner |=> !faulted;
  endproperty
  a_inner_clear: assert property (p_inner_clear) else $error("inner pass kept fault"); // R7

  property p_inner_keep;
    ce && mon_en && !stale && edge_ev && armed && faulted && !in_inner |=> faulted;
  endproperty
  a_inner_keep: assert property (p_inner_keep) else $error("fault cleared outside inner"); // R7

  property p_outer_set;
    ce && mon_en && edge_ev && armed && !faulted && !in_outer |=> faulted;
  endproperty
  a_outer_set: assert property (p_outer_set) else $error("outer miss not faulted"); // R8

  property p_fault_invalid;
    faulted |-> !valid;
  endproperty
  a_fault_invalid: assert property (p_fault_invalid) else $error("valid while faulted"); // R15

  property p_force_valid;
    ce && force_val && !next_faulted |=> valid;
  endproperty
  a_force_valid: assert property (p_force_valid) else $error("force did not validate"); // R16

  property p_meas_scale;
    ce && edge_ev |=> meas == $past(next_meas) && (meas_done == $past(armed));
  endproperty
  a_meas_scale: assert property (p_meas_scale) else $error("period not captured"); // R17

endmodule : rpm_ref_mon

//--- core/rpm_top.sv
// Eight reference period monitors with committed settings and reference selection.
`timescale 1ns/100ps
// Functional notes
// R1: References stay faulted until system clock stable.
// R2: Eight references, each with own monitor.
// R3: Period measured continuously; each measurement decides fault.
// R4: Compare against assigned profile's period and tolerances.
// R5: Nominal period is 50-bit femtoseconds.
// R6: Tolerances are 20-bit reciprocal fractions.
// R7: Faulted clears only within inner tolerance.
// R8: Nonfaulted faults beyond outer tolerance.
// R9: Software keeps inner tighter than outer.
// R10: Auto assignment picks profile from measurements.
// R11: Settings apply only on update strobe.
// R12: Manual: select best-priority valid reference.
// R13: Software writes detect select, then update.
// R14: After auto detection, select best-priority valid.
// R15: Faulted reference forces valid low immediately.
// R16: Zero validation time needs manual force.
// R17: Period is cycle count times system period.
module rpm_top #(
  parameter int MS_CYCLES_P = rpm_pkg::MS_CYCLES
) (
  // Clock, reset and freeze.
  input  wire logic                                     clk,
  input  wire logic                                     rstn,
  input  wire logic                                     ce,
  // Register port.
  input  wire logic                                     reg_we,
  input  wire logic [rpm_pkg::ADDR_W-1:0]               reg_addr,
  input  wire logic [rpm_pkg::DATA_W-1:0]               reg_wdata,
  output logic      [rpm_pkg::DATA_W-1:0]               reg_rdata,
  // Reference pins.
  input  wire logic [rpm_pkg::NREF-1:0]                 ref_in,
  // System clock status and staged settings.
  input  wire logic                                     sysclk_stable,
  input  wire logic [rpm_pkg::SPER_W-1:0]               sysclk_period_in,
  input  wire logic [rpm_pkg::NPROF*rpm_pkg::PER_W-1:0]  prof_period_in,
  input  wire logic [rpm_pkg::NPROF*rpm_pkg::TOL_W-1:0]  prof_inner_in,
  input  wire logic [rpm_pkg::NPROF*rpm_pkg::TOL_W-1:0]  prof_outer_in,
  input  wire logic [rpm_pkg::NPROF*rpm_pkg::PRIO_W-1:0] prof_prio_in,
  input  wire logic [rpm_pkg::NPROF*rpm_pkg::VAL_W-1:0]  prof_val_in,
  input  wire logic [rpm_pkg::NREF*rpm_pkg::CFG_W-1:0]   ref_cfg_in,
  // Manual validation pulses.
  input  wire logic [rpm_pkg::NREF-1:0]                 force_val,
  // Status and selection.
  output logic      [rpm_pkg::NREF-1:0]                 ref_faulted,
  output logic      [rpm_pkg::NREF-1:0]                 ref_valid,
  output logic      [rpm_pkg::REF_W-1:0]                sel_ref,
  output logic                                          sel_ok
);
  import rpm_pkg::*;

  // Committed copies; software changes to the staged inputs wait for an update.
  logic [SPER_W-1:0]       act_sper;
  logic [NPROF*PER_W-1:0]  act_per;
  logic [NPROF*TOL_W-1:0]  act_inner;
  logic [NPROF*TOL_W-1:0]  act_outer;
  logic [NPROF*PRIO_W-1:0] act_prio;
  logic [NPROF*VAL_W-1:0]  act_val;
  logic [NREF*CFG_W-1:0]   act_cfg;
  logic [DATA_W-1:0]       detect_sel;
  logic [MS_W-1:0]         ms_cnt;
  logic                    ms_tick;
  logic [REF_W-1:0]        next_sel;
  logic                    next_ok;
  logic [PRIO_W-1:0]       best;
  wire  [NREF*PRIO_W-1:0]  prio_v;

  // Register decode; the update strobe is self-clearing and reads as zero.
  wire                     wr_upd     = ce && reg_we && (reg_addr == ADDR_UPDATE);
  wire                     wr_det     = ce && reg_we && (reg_addr == ADDR_DETECT);
  wire                     commit     = wr_upd && reg_wdata[UPDATE_BIT];
  wire                     ms_wrap    = (ms_cnt == MS_W'(MS_CYCLES_P - 1));
  wire [DATA_W-1:0]        next_rdata = (reg_addr == ADDR_DETECT) ? detect_sel  :
                                        (reg_addr == ADDR_FAULT)  ? ref_faulted :
                                        (reg_addr == ADDR_VALID)  ? ref_valid   : '0;

  // Register port, read data and detect select.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      detect_sel <= '0;
      reg_rdata  <= '0;
    end else if (ce) begin
      reg_rdata <= next_rdata;
      if (wr_det) begin
        detect_sel <= reg_wdata;
      end
    end
  end

  // R11: commit on update
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      act_sper  <= '0;
      act_per   <= '0;
      act_inner <= '0;
      act_outer <= '0;
      act_prio  <= '0;
      act_val   <= '0;
      act_cfg   <= '0;
    end else if (commit) begin
      act_sper  <= sysclk_period_in;
      act_per   <= prof_period_in;
      act_inner <= prof_inner_in;
      act_outer <= prof_outer_in;
      act_prio  <= prof_prio_in;
      act_val   <= prof_val_in;
      act_cfg   <= ref_cfg_in;
    end
  end

  // Millisecond tick for the validation timers; shorten MS_CYCLES_P in simulation.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ms_cnt  <= '0;
      ms_tick <= 1'b0;
    end else if (ce) begin
      ms_tick <= ms_wrap;
      ms_cnt  <= ms_wrap ? '0 : ms_cnt + 1'b1;
    end
  end

  // R2: one monitor per reference
  for (genvar i = 0; i < NREF; i++) begin : g_ref
    rpm_asg_e          st, next_st;
    logic [PROF_W-1:0] prof, next_prof, hit_p;
    logic              hit;
    logic [PER_W-1:0]  meas;
    logic              meas_done;
    wire  [CFG_W-1:0]  cfg_new = ref_cfg_in[CFG_W*i +: CFG_W];

    // R10: first matching profile
    always_comb begin
      hit   = 1'b0;
      hit_p = '0;
      for (int k = NPROF - 1; k >= 0; k--) begin
        if (act_per[PER_W*k +: PER_W] != '0 &&
            rpm_within(meas, act_per[PER_W*k +: PER_W], act_outer[TOL_W*k +: TOL_W])) begin
          hit   = 1'b1;
          hit_p = PROF_W'(k);
        end
      end
    end

    // Assignment machine; an update restarts or fixes the assignment.
    always_comb begin
      next_st   = st;
      next_prof = prof;
      case (st)
        ASG_IDLE, ASG_DONE: begin
          next_st = st;
        end
        ASG_RUN: begin
          if (meas_done && hit) begin
            next_st   = ASG_DONE;
            next_prof = hit_p;
          end
        end
        default: begin
          next_st = ASG_IDLE;
        end
      endcase
      if (commit) begin
        if (cfg_new[CFG_MANUAL]) begin
          next_st   = ASG_DONE;
          next_prof = cfg_new[PROF_W-1:0];
        end else if (detect_sel[i]) begin
          next_st = ASG_RUN;
        end
      end
    end

    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        st   <= ASG_IDLE;
        prof <= '0;
      end else if (ce) begin
        st   <= next_st;
        prof <= next_prof;
      end
    end

    assign prio_v[PRIO_W*i +: PRIO_W] = act_prio[PRIO_W*prof +: PRIO_W];

    // R4: assigned profile parameters; R5: 50-bit fs; R6: 20-bit reciprocal
    rpm_ref_mon u_mon (
      .clk           (clk),
      .rstn          (rstn),
      .ce            (ce),
      .ref_in        (ref_in[i]),
      .sysclk_period (act_sper),
      .nom           (act_per[PER_W*prof +: PER_W]),
      .tol_inner     (act_inner[TOL_W*prof +: TOL_W]),
      .tol_outer     (act_outer[TOL_W*prof +: TOL_W]),
      .val_ms        (act_val[VAL_W*prof +: VAL_W]),
      .mon_en        (sysclk_stable && st == ASG_DONE),
      .ms_tick       (ms_tick),
      .force_val     (force_val[i]),
      .meas          (meas),
      .meas_done     (meas_done),
      .faulted       (ref_faulted[i]),
      .valid         (ref_valid[i])
    );

    property p_auto_done;
      ce && !commit && st == ASG_RUN && meas_done && hit |=> st == ASG_DONE && prof == $past(hit_p);
    endproperty
    a_auto_done: assert property (@(posedge clk) disable iff (!rstn) p_auto_done) else $error("auto assignment missed"); // R10
  end

  // R12, R14: best-priority valid reference
  always_comb begin
    next_sel = sel_ref;
    next_ok  = 1'b0;
    best     = '0;
    for (int k = NREF - 1; k >= 0; k--) begin
      if (ref_valid[k] && (!next_ok || prio_v[PRIO_W*k +: PRIO_W] <= best)) begin
        next_ok  = 1'b1;
        best     = prio_v[PRIO_W*k +: PRIO_W];
        next_sel = REF_W'(k);
      end
    end
  end

  // Selection is registered, so it trails a valid change by one cycle.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_ref <= '0;
      sel_ok  <= 1'b0;
    end else if (ce) begin
      sel_ref <= next_sel;
      sel_ok  <= next_ok;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_commit;
    ce && reg_we && reg_addr == ADDR_UPDATE && reg_wdata[UPDATE_BIT];
  endsequence

  property p_commit_copy;
    s_commit |=> act_cfg == $past(ref_cfg_in) && act_per == $past(prof_period_in);
  endproperty
  a_commit_copy: assert property (p_commit_copy) else $error("update did not commit"); // R11

  property p_no_commit_hold;
    !commit |=> $stable(act_cfg) && $stable(act_outer);
  endproperty
  a_no_commit_hold: assert property (p_no_commit_hold) else $error("settings changed without update"); // R11

  // The new index is held against the valid vector it was chosen from.
  property p_sel_valid;
    (ce ##1 sel_ok) |-> (($past(ref_valid) >> sel_ref) & NREF'(1)) != '0;
  endproperty
  a_sel_valid: assert property (p_sel_valid) else $error("selected reference not valid"); // R12

  property p_sel_none;
    ce && ref_valid == '0 |=> !sel_ok;
  endproperty
  a_sel_none: assert property (p_sel_none) else $error("selection without valid reference"); // R14

endmodule : rpm_top

//--- tb/rpm_ref_src.sv
// Reference clock sources standing at the monitor's eight reference pins.
`timescale 1ns/100ps
module rpm_ref_src (
  // Half period per source in ns; zero stops that source.
  input  wire logic [127:0] half_ns,
  // Reference pins.
  output logic      [7:0]   ref_out
);
  // Each source runs on its own timer, 3 ns off the clock edges to avoid sampling races.
  for (genvar i = 0; i < 8; i++) begin : g_src
    logic lvl;
    initial begin
      lvl = 1'b0;
      #3;
      forever begin
        if (half_ns[i*16 +: 16] == 16'h0000) begin
          // A stopped source rests at the receiver's pull-down level.
          lvl = 1'b0;
          #10;
        end else begin
          #(half_ns[i*16 +: 16]);
          lvl = ~lvl;
        end
      end
    end
    assign ref_out[i] = lvl;
  end
endmodule : rpm_ref_src

//--- tb/rpm_top_tb.sv
// Self-checking bench of the reference period monitor array.
`timescale 1ns/100ps
module rpm_top_tb;
  import rpm_pkg::*;
  // Short millisecond tick keeps the validation waits brief.
  localparam int MSC = 4;
  logic                    clk, rstn, reg_we, sysclk_stable, sel_ok;
  logic [ADDR_W-1:0]       reg_addr;
  logic [DATA_W-1:0]       reg_wdata, reg_rdata;
  logic [NREF-1:0]         ref_in, force_val, ref_faulted, ref_valid;
  logic [SPER_W-1:0]       sper;
  logic [NPROF*PER_W-1:0]  pper;
  logic [NPROF*TOL_W-1:0]  pin, pout;
  logic [NPROF*PRIO_W-1:0] pprio;
  logic [NPROF*VAL_W-1:0]  pval;
  logic [NREF*CFG_W-1:0]   cfg;
  logic [REF_W-1:0]        sel_ref;
  logic [127:0]            half;
  logic [7:0]              good, vexp;
  logic [2:0]              pmap [8];
  int                      error_cnt, checked, seed;

  rpm_top #(.MS_CYCLES_P(MSC)) DUT (
    .clk(clk), .rstn(rstn), .ce(1'b1), .reg_we(reg_we), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ref_in(ref_in),
    .sysclk_stable(sysclk_stable), .sysclk_period_in(sper), .prof_period_in(pper),
    .prof_inner_in(pin), .prof_outer_in(pout), .prof_prio_in(pprio), .prof_val_in(pval),
    .ref_cfg_in(cfg), .force_val(force_val), .ref_faulted(ref_faulted),
    .ref_valid(ref_valid), .sel_ref(sel_ref), .sel_ok(sel_ok)
  );
  rpm_ref_src SRC (.half_ns(half), .ref_out(ref_in));

  // Free-running 50 MHz clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Ends the run with the verdict.
  task automatic test_done();
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : wr

  // Read data shows one edge after the address is taken.
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    #1;
    chk(reg_rdata, exp, what);
  endtask : rd

  // Bounded wait for a status vector; running out counts as a mismatch.
  task automatic wait_eq(input bit use_valid, input logic [7:0] exp, input string what);
    int n;
    n = 0;
    while ((use_valid ? ref_valid : ref_faulted) !== exp && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(use_valid ? ref_valid : ref_faulted, exp, what);
    // A wait that ran out has just counted its mismatch, so end the run.
    if ((use_valid ? ref_valid : ref_faulted) !== exp) test_done();
  endtask : wait_eq

  // Best priority valid reference, lowest index on a tie; bit 3 says one exists.
  function automatic logic [3:0] exp_sel(input logic [7:0] v);
    logic [3:0] r;
    logic [2:0] best;
    r = 4'h0;
    best = 3'h7;
    for (int i = 0; i < 8; i++) begin
      if (v[i] && (!r[3] || pprio[pmap[i]*PRIO_W +: PRIO_W] < best)) begin
        best = pprio[pmap[i]*PRIO_W +: PRIO_W];
        r = {1'b1, i[2:0]};
      end
    end
    return r;
  endfunction : exp_sel

  always @(negedge clk) begin
    if (rstn === 1'b1) chk(ref_faulted & ref_valid, 8'h00, "valid while faulted");
  end

  initial begin
    seed = 97711;
    error_cnt = 0;
    checked = 0;
    rstn = 1'b0;
    reg_we = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    sysclk_stable = 1'b0;
    force_val = '0;
    sper = 25'd20000000;
    good = 8'($random(seed));
    good[0] = 1'b1;
    good[7] = 1'b1;
    // profiles with tight inner and wide outer tolerances
    for (int k = 0; k < 8; k++) begin
      pmap[k] = k[2:0];
      pper[k*PER_W +: PER_W] = PER_W'(k + 1) * 50'd400000000;
      pin[k*TOL_W +: TOL_W] = 20'h04e20;
      pout[k*TOL_W +: TOL_W] = 20'h0000a;
      pprio[k*PRIO_W +: PRIO_W] = 3'($random(seed));
      pval[k*VAL_W +: VAL_W] = (k == 0) ? 16'h0000 : 16'h0002;
      cfg[k*CFG_W +: CFG_W] = {1'b1, k[2:0]};
      half[k*16 +: 16] = 16'((k + 1) * (good[k] ? 200 : 240));
    end
    repeat (6) @(posedge clk);
    #1;
    chk(ref_faulted, 8'hff, "reset fault");
    chk(ref_valid, 8'h00, "reset valid");
    @(posedge clk);
    rstn <= 1'b1;
    sysclk_stable <= 1'b1;
    wr(ADDR_UPDATE, 8'hfe);
    repeat (400) @(posedge clk);
    #1;
    chk(ref_faulted, 8'hff, "no commit without strobe");
    @(posedge clk);
    sysclk_stable <= 1'b0;
    wr(ADDR_UPDATE, 8'h01);
    repeat (400) @(posedge clk);
    #1;
    chk(ref_faulted, 8'hff, "fault while clock unstable");
    @(posedge clk);
    sysclk_stable <= 1'b1;
    wait_eq(1'b0, ~good, "period decision");
    vexp = good & 8'hfe;
    wait_eq(1'b1, vexp, "validation timer");
    repeat (20) @(posedge clk);
    #1;
    chk(ref_valid, vexp, "no timer when zero");
    @(posedge clk);
    force_val[0] <= 1'b1;
    @(posedge clk);
    force_val[0] <= 1'b0;
    vexp = good;
    wait_eq(1'b1, vexp, "forced validation");
    repeat (2) @(posedge clk);
    #1;
    chk({4'h0, sel_ok, sel_ref}, {4'h0, exp_sel(vexp)}, "manual selection");
    rd(ADDR_FAULT, ~good, "fault status");
    rd(ADDR_UPDATE, 8'h00, "update reads zero");
    rd(16'h1234, 8'h00, "unmapped read");
    @(posedge clk);
    half[15:0] <= 16'd210;
    repeat (300) @(posedge clk);
    #1;
    chk(ref_faulted, ~good, "inside outer band");
    @(posedge clk);
    half[15:0] <= 16'd240;
    wait_eq(1'b0, ~good | 8'h01, "beyond outer band");
    chk(ref_valid, good & 8'hfe, "valid drops on fault");
    @(posedge clk);
    half[15:0] <= 16'd210;
    repeat (300) @(posedge clk);
    #1;
    chk(ref_faulted, ~good | 8'h01, "outside inner band");
    @(posedge clk);
    half[15:0] <= 16'd200;
    wait_eq(1'b0, ~good, "inside inner band");
    // automatic detection moves reference 2 to profile 4
    @(posedge clk);
    cfg[8 +: 4] <= 4'h0;
    half[32 +: 16] <= 16'd1000;
    pmap[2] = 3'h4;
    // Let the mixed old and new half periods drain before detection starts.
    repeat (200) @(posedge clk);
    vexp = (good & 8'hfe) | 8'h04;
    wr(ADDR_DETECT, 8'h04);
    rd(ADDR_DETECT, 8'h04, "detect select");
    wr(ADDR_UPDATE, 8'h01);
    wait_eq(1'b1, vexp, "auto profile valid");
    chk(ref_faulted, ~(good | 8'h04), "auto profile fault");
    repeat (2) @(posedge clk);
    #1;
    chk({4'h0, sel_ok, sel_ref}, {4'h0, exp_sel(vexp)}, "auto selection");
    test_done();
  end
endmodule : rpm_top_tb
